// ### rtl/xadl_core.sv
`timescale 1ns/1ps
// Operation
// RULE1: direction load copies working register into chosen direction register; flags untouched.
// RULE2: operand 5 selects port A, 6 port B, 7 port C; others ignored. Code decodes only file_addr_i[2:0], so operands such as 0x0D also load port A.
// RULE3: literal XOR puts working register XOR literal into working register.
// RULE4: file XOR with destination 0 puts result into working register.
// RULE5: file XOR with destination 1 writes file register, working register kept.
// RULE6: both XORs update only zero flag, set when result is zero.
module xadl_core #(
    parameter int DATA_W = xadl_pkg::DATA_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire logic [1:0] op_code_i,
    input wire logic [7:0] literal_i,
    input wire logic [6:0] file_addr_i,
    input wire logic dest_i,
    input wire logic [7:0] file_rdata_i,
    output logic [7:0] wreg_o,
    output logic [7:0] port_a_direction_o,
    output logic [7:0] port_b_direction_o,
    output logic [7:0] port_c_direction_o,
    output logic zero_flag_o,
    output logic file_we_o,
    output logic [6:0] file_waddr_o,
    output logic [7:0] file_wdata_o
);
    // Width check
    if (DATA_W != 8) begin : g_width_check
        $error("xadl_core supports only 8-bit data");
    end

    logic [7:0] wreg_ff, nxt_wreg;
    logic [7:0] dir_a_ff, nxt_dir_a;
    logic [7:0] dir_b_ff, nxt_dir_b;
    logic [7:0] dir_c_ff, nxt_dir_c;
    logic zero_ff, nxt_zero;
    logic fwe_ff, nxt_fwe;
    logic [6:0] fwaddr_ff, nxt_fwaddr;
    logic [7:0] fwdata_ff, nxt_fwdata;
    logic [7:0] xor_res;
    xadl_pkg::xadl_op_type op;
    logic do_dir, do_xlit, do_xfile;

    assign op = xadl_pkg::xadl_op_type'(op_code_i);

    // Decoded strobes, only while the decoder marks the op valid
    assign do_dir = op_valid_i && (op == xadl_pkg::OP_DIR_LOAD);
    assign do_xlit = op_valid_i && (op == xadl_pkg::OP_XOR_LIT);
    assign do_xfile = op_valid_i && (op == xadl_pkg::OP_XOR_FILE);

    // Shared XOR unit; second operand picked by the op
    always_comb begin
        xor_res = 8'h00;
        if (op == xadl_pkg::OP_XOR_LIT) begin
            xor_res = wreg_ff ^ literal_i; // see RULE3
        end else if (op == xadl_pkg::OP_XOR_FILE) begin
            xor_res = wreg_ff ^ file_rdata_i; // see RULE4
        end
    end

    // Working register and zero flag: next values
    always_comb begin
        nxt_wreg = wreg_ff;
        nxt_zero = zero_ff;
        if (do_xlit) begin
            nxt_wreg = xor_res; // see RULE3
        end
        if (do_xfile && dest_i == xadl_pkg::DEST_WREG) begin
            nxt_wreg = xor_res; // see RULE4
        end
        // Only the XORs touch the flag; direction loads keep it
        if (do_xlit || do_xfile) begin
            nxt_zero = (xor_res == 8'h00); // see RULE6
        end
    end

    // Working register and zero flag: registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wreg_ff <= xadl_pkg::WREG_RST;
            zero_ff <= xadl_pkg::ZERO_RST;
        end else begin
            wreg_ff <= nxt_wreg;
            zero_ff <= nxt_zero;
        end
    end

    // Direction registers: next values, operands whose low three bits are below 5 ignored
    always_comb begin
        nxt_dir_a = dir_a_ff;
        nxt_dir_b = dir_b_ff;
        nxt_dir_c = dir_c_ff;
        if (do_dir) begin
            // Operand sits in low address bits
            case (file_addr_i[2:0])
                xadl_pkg::SEL_PORT_A: nxt_dir_a = wreg_ff; // see RULE1 RULE2
                xadl_pkg::SEL_PORT_B: nxt_dir_b = wreg_ff; // see RULE1 RULE2
                xadl_pkg::SEL_PORT_C: nxt_dir_c = wreg_ff; // see RULE1 RULE2
                default: ;
            endcase
        end
    end

    // Direction registers: registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_a_ff <= xadl_pkg::DIR_RST;
            dir_b_ff <= xadl_pkg::DIR_RST;
            dir_c_ff <= xadl_pkg::DIR_RST;
        end else begin
            dir_a_ff <= nxt_dir_a;
            dir_b_ff <= nxt_dir_b;
            dir_c_ff <= nxt_dir_c;
        end
    end

    // File write port: next values, strobe lasts one cycle
    always_comb begin
        nxt_fwe = 1'b0;
        nxt_fwaddr = fwaddr_ff;
        nxt_fwdata = fwdata_ff;
        if (do_xfile && dest_i == xadl_pkg::DEST_FILE) begin
            nxt_fwe = 1'b1; // see RULE5
            nxt_fwaddr = file_addr_i;
            nxt_fwdata = xor_res;
        end
    end

    // File write port: registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fwe_ff <= 1'b0;
            fwaddr_ff <= xadl_pkg::FADDR_RST;
            fwdata_ff <= xadl_pkg::FDATA_RST;
        end else begin
            fwe_ff <= nxt_fwe;
            fwaddr_ff <= nxt_fwaddr;
            fwdata_ff <= nxt_fwdata;
        end
    end

    // Outputs straight from flops
    assign wreg_o = wreg_ff;
    assign port_a_direction_o = dir_a_ff;
    assign port_b_direction_o = dir_b_ff;
    assign port_c_direction_o = dir_c_ff;
    assign zero_flag_o = zero_ff;
    assign file_we_o = fwe_ff;
    assign file_waddr_o = fwaddr_ff;
    assign file_wdata_o = fwdata_ff;

    // Checks on the execute stage
    dir_load_a_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE1 RULE2
        op_valid_i && op == xadl_pkg::OP_DIR_LOAD && file_addr_i[2:0] == 3'h5
        |=> port_a_direction_o == $past(wreg_o) && $stable(zero_flag_o) && $stable(wreg_o))
        else $error("port A direction not loaded");
    dir_load_b_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE2
        op_valid_i && op == xadl_pkg::OP_DIR_LOAD && file_addr_i[2:0] == 3'h6
        |=> port_b_direction_o == $past(wreg_o) && $stable(port_a_direction_o) && $stable(port_c_direction_o))
        else $error("port B direction not loaded");
    dir_load_c_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE2
        op_valid_i && op == xadl_pkg::OP_DIR_LOAD && file_addr_i[2:0] == 3'h7
        |=> port_c_direction_o == $past(wreg_o) && $stable(port_b_direction_o))
        else $error("port C direction not loaded");
    dir_invalid_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE2
        op_valid_i && op == xadl_pkg::OP_DIR_LOAD && file_addr_i[2:0] < 3'h5
        |=> $stable(port_a_direction_o) && $stable(port_b_direction_o) && $stable(port_c_direction_o))
        else $error("invalid operand changed a direction register");
    xor_literal_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE3
        op_valid_i && op == xadl_pkg::OP_XOR_LIT
        |=> wreg_o == ($past(wreg_o) ^ $past(literal_i)) && !file_we_o)
        else $error("literal XOR result wrong");
    xor_to_wreg_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE4
        op_valid_i && op == xadl_pkg::OP_XOR_FILE && !dest_i
        |=> wreg_o == ($past(wreg_o) ^ $past(file_rdata_i)) && !file_we_o)
        else $error("file XOR to working register wrong");
    xor_to_file_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE5
        op_valid_i && op == xadl_pkg::OP_XOR_FILE && dest_i
        |=> file_we_o && file_waddr_o == $past(file_addr_i)
            && file_wdata_o == ($past(wreg_o) ^ $past(file_rdata_i)) && $stable(wreg_o))
        else $error("file XOR write-back wrong");
    zero_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE6
        op_valid_i && (op == xadl_pkg::OP_XOR_LIT || op == xadl_pkg::OP_XOR_FILE)
        |=> zero_flag_o == ((($past(wreg_o) ^ (($past(op_code_i) == 2'b10) ? $past(literal_i)
            : $past(file_rdata_i)))) == 8'h00))
        else $error("zero flag wrong after XOR");

    // Nothing moves without a valid XOR or direction load
    idle_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE1
        !op_valid_i || op == xadl_pkg::OP_NONE
        |=> $stable(wreg_o) && $stable(zero_flag_o) && !file_we_o && $stable(port_a_direction_o)
            && $stable(port_b_direction_o) && $stable(port_c_direction_o))
        else $error("state changed without a valid op");
    dir_load_flags_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE1
        do_dir
        |=> $stable(zero_flag_o) && $stable(wreg_o) && !file_we_o)
        else $error("direction load touched flag or working register");
    dir_a_source_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE2
        $changed(port_a_direction_o)
        |-> $past(do_dir && file_addr_i[2:0] == xadl_pkg::SEL_PORT_A))
        else $error("port A direction changed without its load");
    dir_b_source_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE2
        $changed(port_b_direction_o)
        |-> $past(do_dir && file_addr_i[2:0] == xadl_pkg::SEL_PORT_B))
        else $error("port B direction changed without its load");
    dir_c_source_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE2
        $changed(port_c_direction_o)
        |-> $past(do_dir && file_addr_i[2:0] == xadl_pkg::SEL_PORT_C))
        else $error("port C direction changed without its load");
    wreg_source_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE5
        $changed(wreg_o)
        |-> $past(do_xlit || (do_xfile && dest_i == xadl_pkg::DEST_WREG)))
        else $error("working register changed without an XOR into it");
    zero_source_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE6
        $changed(zero_flag_o)
        |-> $past(do_xlit || do_xfile))
        else $error("zero flag changed without an XOR");
    we_source_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE5
        file_we_o
        |-> $past(do_xfile && dest_i == xadl_pkg::DEST_FILE))
        else $error("file write strobe without a file XOR");
    write_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // see RULE5
        !file_we_o
        |-> $stable(file_waddr_o) && $stable(file_wdata_o))
        else $error("file write address or data moved without a write");
endmodule

// ### rtl/xadl_pkg.sv
package xadl_pkg;
    // Data path width
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    // Direction-load operand selectors
    localparam logic [2:0] SEL_PORT_A = 3'h5;
    localparam logic [2:0] SEL_PORT_B = 3'h6;
    localparam logic [2:0] SEL_PORT_C = 3'h7;
    // Destination bit encodings for the file XOR
    localparam logic DEST_WREG = 1'h0;
    localparam logic DEST_FILE = 1'h1;
    // Values after reset
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic ZERO_RST = 1'h0;
    localparam logic [6:0] FADDR_RST = 7'h00;
    localparam logic [7:0] FDATA_RST = 8'h00;
    // Operation codes presented by the instruction decoder
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_DIR_LOAD = 2'b01,
        OP_XOR_LIT = 2'b10,
        OP_XOR_FILE = 2'b11
    } xadl_op_type;
endpackage

// ### tb/xor_and_direction_load_ops_tb.sv
`timescale 1ns/1ps
module xor_and_direction_load_ops_tb;
    logic ref_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic op_valid_i = 1'h0;
    logic [1:0] op_code_i = 2'h0;
    logic [7:0] literal_i = 8'h00;
    logic [6:0] file_addr_i = 7'h00;
    logic dest_i = 1'h0;
    logic [7:0] file_rdata_i = 8'h00;
    logic [7:0] wreg_o, dir_a, dir_b, dir_c, file_wdata_o;
    logic [6:0] file_waddr_o;
    logic zero_flag_o, file_we_o;
    logic [7:0] exp_w = 8'h00;
    int failures = 0;
    int n_compared = 0;

    // Device under test
    xadl_core i_xadl_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
        .op_code_i(op_code_i), .literal_i(literal_i), .file_addr_i(file_addr_i), .dest_i(dest_i),
        .file_rdata_i(file_rdata_i), .wreg_o(wreg_o), .port_a_direction_o(dir_a),
        .port_b_direction_o(dir_b), .port_c_direction_o(dir_c), .zero_flag_o(zero_flag_o),
        .file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o));

    // Clock at 100 MHz
    always #5 ref_clk_i = ~ref_clk_i;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One operation, then results are settled after the taking edge
    task automatic run_op(input logic [1:0] code, input logic [7:0] lit, input logic [6:0] addr,
        input logic d, input logic [7:0] rd);
        @(posedge ref_clk_i);
        op_valid_i <= 1'h1;
        op_code_i <= code;
        literal_i <= lit;
        file_addr_i <= addr;
        dest_i <= d;
        file_rdata_i <= rd;
        @(posedge ref_clk_i);
        op_valid_i <= 1'h0;
        #1;
    endtask

    // Bring the working register to a known value
    task automatic set_w(input logic [7:0] v);
        run_op(xadl_pkg::OP_XOR_LIT, exp_w ^ v, 7'h00, 1'h0, 8'h00);
        exp_w = v;
    endtask

    // Direction loads, operand 4 refused, flag kept set
    task automatic t_dir();
        logic [7:0] dirs [3];
        dirs = '{8'hFF, 8'hFF, 8'hFF};
        for (int s = 4; s <= 7; s++) begin
            set_w(8'hA0 | 8'(s));
            run_op(xadl_pkg::OP_XOR_FILE, 8'h00, 7'h2C, 1'h1, exp_w);
            run_op(xadl_pkg::OP_DIR_LOAD, 8'h00, {4'hF, 3'(s)}, 1'h0, 8'h00);
            if (s > 4) dirs[s - 5] = exp_w;
            chk("zero", 8'h01, {7'h00, zero_flag_o});
            chk("dir_a", dirs[0], dir_a);
            chk("dir_b", dirs[1], dir_b);
            chk("dir_c", dirs[2], dir_c);
        end
    endtask

    // Literal and file XOR with both destinations
    task automatic t_xor();
        set_w(8'h3C);
        run_op(xadl_pkg::OP_XOR_LIT, 8'h3C, 7'h00, 1'h0, 8'h00);
        chk("wreg", 8'h00, wreg_o);
        chk("zero", 8'h01, {7'h00, zero_flag_o});
        run_op(xadl_pkg::OP_XOR_LIT, 8'h5A, 7'h00, 1'h0, 8'h00);
        chk("wreg", 8'h5A, wreg_o);
        chk("zero", 8'h00, {7'h00, zero_flag_o});
        run_op(xadl_pkg::OP_XOR_FILE, 8'h00, 7'h11, 1'h0, 8'h0F);
        chk("wreg", 8'h5A ^ 8'h0F, wreg_o);
        chk("we", 8'h00, {7'h00, file_we_o});
        run_op(xadl_pkg::OP_XOR_FILE, 8'h00, 7'h20, 1'h1, 8'hA5);
        chk("we", 8'h01, {7'h00, file_we_o});
        chk("waddr", 8'h20, {1'h0, file_waddr_o});
        chk("wdata", 8'h55 ^ 8'hA5, file_wdata_o);
        chk("wreg", 8'h55, wreg_o);
        @(posedge ref_clk_i);
        #1;
        chk("we", 8'h00, {7'h00, file_we_o});
        run_op(xadl_pkg::OP_XOR_FILE, 8'h00, 7'h12, 1'h0, 8'h55);
        chk("wreg", 8'h00, wreg_o);
        chk("zero", 8'h01, {7'h00, zero_flag_o});
        run_op(xadl_pkg::OP_NONE, 8'hFF, 7'h05, 1'h1, 8'hFF);
        chk("wreg", 8'h00, wreg_o);
        chk("zero", 8'h01, {7'h00, zero_flag_o});
        chk("dir_a", 8'hA5, dir_a);
        chk("we", 8'h00, {7'h00, file_we_o});
    endtask

    // Every output at its value after reset
    task automatic t_reset_vals();
        chk("wreg", xadl_pkg::WREG_RST, wreg_o);
        chk("dir_a", xadl_pkg::DIR_RST, dir_a);
        chk("dir_b", xadl_pkg::DIR_RST, dir_b);
        chk("dir_c", xadl_pkg::DIR_RST, dir_c);
        chk("zero", {7'h00, xadl_pkg::ZERO_RST}, {7'h00, zero_flag_o});
        chk("we", 8'h00, {7'h00, file_we_o});
        chk("waddr", {1'h0, xadl_pkg::FADDR_RST}, {1'h0, file_waddr_o});
        chk("wdata", xadl_pkg::FDATA_RST, file_wdata_o);
    endtask

    // Reset in mid-run, then an op taken on the second edge after release
    task automatic t_reset_mid();
        run_op(xadl_pkg::OP_XOR_LIT, 8'h3A, 7'h00, 1'h0, 8'h00);
        run_op(xadl_pkg::OP_XOR_FILE, 8'h00, 7'h31, 1'h1, 8'h3A);
        @(posedge ref_clk_i);
        rst_i <= 1'h1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        #1;
        t_reset_vals();
        exp_w = xadl_pkg::WREG_RST;
        set_w(8'h81);
        chk("wreg", 8'h81, wreg_o);
        chk("zero", 8'h00, {7'h00, zero_flag_o});
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        #1;
        t_reset_vals();
        t_dir();
        t_xor();
        t_reset_mid();
        tally_and_finish();
    end

    // Watchdog
    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
endmodule
